/* File: tb_tdrs_spi_readout.sv */
// self-checking bench for the tdc readout serial port
`timescale 1ns/10ps
`include "tdrs_consts.svh"
module tb_tdrs_spi_readout;
    import tdrs_pkg::*;
    logic            i_ref_clk, i_reset_n, i_meas_done, i_measure_mode2;
    logic            i_result_we, ssn_n, sck, sdi, o_sdo, o_sdo_oe_n;
    logic            o_interrupt_n, o_config_load_valid, o_nv_busy;
    logic [1:0]      i_result_sel, i_nv_inject;
    logic [7:0]      i_wave_ratio;
    logic [223:0]    i_config, o_config_load;
    tdrs_result_t    i_result;
    tdrs_meas_stat_t i_meas_stat;
    logic [31:0]     res_q [4];
    logic [31:0]     w;
    logic [2:0]      nv_q;
    logic [63:0]     d;
    int              bad_count, compares, seed, loads;

    tdrs_spi_readout u_tdrs_spi_readout (
        .i_ref_clk,
        .i_reset_n,
        .i_slave_select_n (ssn_n),
        .i_sck            (sck),
        .i_sdi            (sdi),
        .o_sdo,
        .o_sdo_oe_n,
        .o_interrupt_n,
        .i_meas_done,
        .i_measure_mode2,
        .i_result,
        .i_result_we,
        .i_result_sel,
        .i_meas_stat,
        .i_wave_ratio,
        .i_config,
        .i_nv_inject,
        .o_config_load,
        .o_config_load_valid,
        .o_nv_busy
    );

    tdrs_spi_master u_tdrs_spi_master (
        .i_ref_clk,
        .i_sdo            (o_sdo_oe_n ? ~o_sdo : o_sdo), // undriven: inverse
        .o_slave_select_n (ssn_n),
        .o_sck            (sck),
        .o_sdi            (sdi)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [223:0] s, input logic [223:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic stop_test();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] op, input int n, input logic [63:0] e);
        u_tdrs_spi_master.frame(op, n, d);
        check(d, e);
    endtask

    // status expectation is built after the frame from the live inputs
    task automatic rds(input logic [15:0] m);
        u_tdrs_spi_master.frame(8'hb4, 16, d);
        check(d & m, {nv_q, i_meas_stat.sensor_short, i_meas_stat.sensor_open,
            i_meas_stat.precount_overflow, i_meas_stat.tdc_overflow,
            i_meas_stat.hits_ch2, i_meas_stat.hits_ch1,
            i_meas_stat.next_free_ptr} & m);
    endtask

    task automatic put(input int s, input logic c, o, m, input logic [31:0] v);
        @(posedge i_ref_clk);
        i_measure_mode2 <= m;
        i_result <= {c, o, v};
        i_result_sel <= s[1:0];
        i_result_we <= 1'b1;
        @(posedge i_ref_clk);
        i_result_we <= 1'b0;
        if (!c) res_q[s] = {v[15:0], 16'h0};
        else if (o && !m) res_q[s] = `TDRS_ALU_OVF_VALUE;
        else res_q[s] = v;
    endtask

    // long nv operations end when busy drops, bounded
    task automatic nv(input logic [7:0] op, input logic [1:0] inj);
        @(posedge i_ref_clk);
        i_nv_inject <= inj;
        u_tdrs_spi_master.frame(op, 0, d);
        repeat (20) @(posedge i_ref_clk);
        for (int i = 0; i < 5000 && o_nv_busy !== 1'b0; i++)
            @(posedge i_ref_clk);
    endtask

    task automatic newcfg();
        @(posedge i_ref_clk);
        for (int i = 0; i < 7; i++) i_config[i*32 +: 32] <= $random(seed);
        i_wave_ratio <= 8'($random(seed));
        @(posedge i_ref_clk);
    endtask

    initial begin
        repeat (30000) @(posedge i_ref_clk); // about three times the run
        bad_count++;
        stop_test();
    end

    // counts load completions seen on the design's pulse output
    always @(posedge i_ref_clk) begin
        if (o_config_load_valid === 1'b1)
            loads++;
    end

    initial begin
        seed = 32'ha84967a2;
        i_reset_n = 1'b0;
        i_meas_done = 1'b0;
        i_measure_mode2 = 1'b0;
        i_result_we = 1'b0;
        i_result_sel = 2'h0;
        i_nv_inject = 2'h0;
        i_result = '0;
        i_meas_stat = '0;
        i_wave_ratio = 8'h00;
        i_config = '0;
        nv_q = 3'h0;
        repeat (16) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        newcfg();
        // every result format, read back whole
        w = $random(seed);
        put(0, 1'b1, 1'b0, 1'b0, $random(seed));
        put(1, 1'b0, 1'b0, 1'b0, {w[15:0], w[15:0]});
        put(2, 1'b1, 1'b1, 1'b0, $random(seed));
        put(3, 1'b1, 1'b0, 1'b1, {1'b0, w[30:0]});
        for (int a = 0; a < 4; a++)
            rd({`TDRS_OP_READ_HI, a[2:0]}, 32, res_q[a]);
        $display("results test done");
        // an aborted read must not upset the next one
        u_tdrs_spi_master.frame(8'hb4, 4, d);
        repeat (3) begin
            w = $random(seed);
            @(posedge i_ref_clk);
            i_meas_stat <= w[12:0];
            rds(16'hffff);
        end
        $display("status test done");
        @(posedge i_ref_clk);
        i_meas_done <= 1'b1;
        @(posedge i_ref_clk);
        i_meas_done <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        check(o_interrupt_n, 1'b0);
        rd(8'hb5, 8, i_config[63:56]);
        check(o_interrupt_n, 1'b1);
        rd(8'hb8, 8, i_wave_ratio);
        rd(8'hb7, 56, i_config[223:168]);
        rd(8'hb6, 8, '0);
        $display("echo and id test done");
        // store, compare equal, change, compare unequal
        nv(8'hc0, 2'b00);
        nv(8'hc6, 2'b00);
        nv_q = 3'b001;
        rds(16'hffff);
        newcfg();
        nv(8'hc6, 2'b00);
        nv_q = 3'b000;
        rds(16'hffff);
        // single flip is corrected and refreshed, double flip is flagged
        nv(8'hc0, 2'b01);
        nv(8'hf0, 2'b00);
        check(o_config_load, i_config);
        nv_q = 3'b100;
        rds(16'hc000);
        nv(8'hc6, 2'b00);
        nv_q = 3'b001;
        rds(16'hffff);
        nv(8'hc0, 2'b11);
        nv(8'hf0, 2'b00);
        nv_q = 3'b010;
        rds(16'hc000);
        check(loads, 2);
        $display("nv store test done");
        stop_test();
    end
endmodule

/* File: tdrs_consts.svh */
// constants for the tdc readout serial port: offsets, fields, opcodes, timing
`ifndef TDRS_CONSTS_SVH
`define TDRS_CONSTS_SVH
`define TDRS_ADR_RESULT_ONE    4'h0
`define TDRS_ADR_RESULT_TWO    4'h1
`define TDRS_ADR_RESULT_THREE  4'h2
`define TDRS_ADR_RESULT_FOUR   4'h3
`define TDRS_ADR_STATUS        4'h4
`define TDRS_ADR_LINK_ECHO     4'h5
`define TDRS_ADR_WAVE_RATIO    4'h8
`define TDRS_OP_READ_HI        5'h16
`define TDRS_OP_READ_ID        8'hb7
`define TDRS_OP_READ_RATIO     8'hb8
`define TDRS_OP_NV_STORE       8'hc0
`define TDRS_OP_NV_LOAD        8'hf0
`define TDRS_OP_NV_COMPARE     8'hc6
`define TDRS_ST_PTR_LSB        0
`define TDRS_ST_HIT1_LSB       3
`define TDRS_ST_HIT2_LSB       6
`define TDRS_ST_TDC_OVF        9
`define TDRS_ST_PRE_OVF        10
`define TDRS_ST_OPEN           11
`define TDRS_ST_SHORT          12
`define TDRS_ST_NV_EQ          13
`define TDRS_ST_NV_DED         14
`define TDRS_ST_NV_SEC         15
`define TDRS_ID_BYTES          7
`define TDRS_NV_WORDS          7
`define TDRS_ALU_OVF_VALUE     32'hffffffff
`define TDRS_SSN_HIGH_NS       50
`define TDRS_CLK_NS            20
`define TDRS_SSN_HIGH_CYC      ((`TDRS_SSN_HIGH_NS + `TDRS_CLK_NS - 1) / `TDRS_CLK_NS)
`endif

/* File: tdrs_nv_store.sv */
// hamming-protected 7x32 config store: store, load and compare only
`timescale 1ns/10ps
`include "tdrs_consts.svh"
module tdrs_nv_store
    import tdrs_pkg::*;
#(
    parameter int WORDS = `TDRS_NV_WORDS
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    input  wire tdrs_nv_op_t          i_op,
    input  wire logic [WORDS*32-1:0]  i_config,
    input  wire logic [1:0]           i_inject,
    output logic [WORDS*32-1:0]       o_loaded,
    output logic                      o_load_valid,
    output logic                      o_equal,
    output logic                      o_single_err,
    output logic                      o_multi_err,
    output logic                      o_busy
);
    // elaboration check: depth held to one to seven words, one short of the 3-bit index range
    if (WORDS < 1 || WORDS > 7) begin
        $error("nv store depth unsupported");
    end

    // 32 data bits, 6 hamming bits and an overall parity bit
    logic [38:0] mem [WORDS];
    logic [2:0]  idx_reg;
    tdrs_nv_op_t op_reg;
    logic        any_sec_reg;
    logic        any_ded_reg;
    logic        eq_reg;
    logic        refresh_reg;

    function automatic logic [5:0] hsyn(input logic [31:0] d);
        logic [5:0] s;
        s = 6'h00;
        for (int b = 0; b < 32; b++) begin
            s = s ^ 6'(b + 1);
            if (!d[b])
                s = s ^ 6'(b + 1);
        end
        return s;
    endfunction

    function automatic logic [38:0] encode(input logic [31:0] d);
        logic [5:0] h;
        h = hsyn(d);
        return {^{d, h}, h, d};
    endfunction

    logic [38:0] cw;
    logic [5:0]  syn;
    logic        par_bad;
    logic [31:0] fixed;
    always_comb begin
        cw      = mem[idx_reg];
        syn     = hsyn(cw[31:0]) ^ cw[37:32];
        par_bad = ^cw;
        fixed   = cw[31:0];
        for (int b = 0; b < 32; b++)
            if (syn == 6'(b + 1) && par_bad)
                fixed[b] = ~cw[b];
    end
    wire sec_hit = par_bad;
    wire ded_hit = (syn != 6'h00) && !par_bad;

    // walk one word per cycle; no path leaves this module except load/compare
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idx_reg      <= 3'h0;
            op_reg       <= TDRS_NV_NONE;
            o_busy       <= 1'b0;
            o_loaded     <= '0;
            o_load_valid <= 1'b0;
            o_equal      <= 1'b0;
            o_single_err <= 1'b0;
            o_multi_err  <= 1'b0;
            any_sec_reg  <= 1'b0;
            any_ded_reg  <= 1'b0;
            eq_reg       <= 1'b0;
            refresh_reg  <= 1'b0;
        end else begin
            o_load_valid <= 1'b0;
            if (!o_busy && i_op != TDRS_NV_NONE) begin
                o_busy      <= 1'b1;
                op_reg      <= i_op;
                idx_reg     <= 3'h0;
                any_sec_reg <= 1'b0;
                any_ded_reg <= 1'b0;
                eq_reg      <= 1'b1;
                refresh_reg <= 1'b0;
            end else if (o_busy && refresh_reg) begin
                for (int w = 0; w < WORDS; w++)  // refresh corrected data
                    mem[w] <= encode(o_loaded[w*32 +: 32]);
                refresh_reg <= 1'b0;
                o_busy      <= 1'b0;
            end else if (o_busy) begin
                if (op_reg == TDRS_NV_STORE) begin
                    mem[idx_reg] <= encode(i_config[idx_reg*32 +: 32])
                                    ^ {37'h0, i_inject};
                end else begin
                    o_loaded[idx_reg*32 +: 32] <= fixed;
                    any_sec_reg <= any_sec_reg | sec_hit;
                    any_ded_reg <= any_ded_reg | ded_hit;
                    if (fixed != i_config[idx_reg*32 +: 32])
                        eq_reg <= 1'b0;
                end
                idx_reg <= idx_reg + 3'h1;
                if (idx_reg == 3'(WORDS - 1)) begin
                    if (op_reg == TDRS_NV_STORE) begin
                        o_busy <= 1'b0;
                    end else begin
                        o_single_err <= any_sec_reg | sec_hit;
                        o_multi_err  <= any_ded_reg | ded_hit;
                        o_equal      <= eq_reg &&
                            fixed == i_config[idx_reg*32 +: 32];
                        o_load_valid <= (op_reg == TDRS_NV_LOAD);
                        refresh_reg  <= any_sec_reg | sec_hit;
                        if (!(any_sec_reg | sec_hit))
                            o_busy <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

/* File: tdrs_pin_sync.sv */
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/10ps
module tdrs_pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic i_ref_clk,
    input  wire logic i_reset_n,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic [2:0] stage_reg;

    // first stage is only read by the second
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage_reg <= {3{RESET_LEVEL}};
            o_level   <= RESET_LEVEL;
        end else begin
            stage_reg <= {stage_reg[1:0], i_pin};
            if (stage_reg[1] == stage_reg[2])
                o_level <= stage_reg[2];
        end
    end

    assign o_rise = (stage_reg[1] == stage_reg[2]) && stage_reg[2] && !o_level;
    assign o_fall = (stage_reg[1] == stage_reg[2]) && !stage_reg[2] && o_level;
endmodule

/* File: tdrs_pkg.sv */
// types shared by the tdc readout serial port
package tdrs_pkg;
    typedef enum logic [1:0] {
        TDRS_NV_NONE,
        TDRS_NV_STORE,
        TDRS_NV_LOAD,
        TDRS_NV_COMPARE
    } tdrs_nv_op_t;

    // event/state inputs that build the status word
    typedef struct packed {
        logic [2:0] next_free_ptr;
        logic [2:0] hits_ch1;
        logic [2:0] hits_ch2;
        logic       tdc_overflow;
        logic       precount_overflow;
        logic       sensor_open;
        logic       sensor_short;
    } tdrs_meas_stat_t;

    // one result as the measurement engine hands it over
    typedef struct packed {
        logic        calibrated;
        logic        alu_overflow;
        logic [31:0] value;
    } tdrs_result_t;
endpackage

/* File: tdrs_spi_master.sv */
// behavioural spi host driving the readout port in clock mode one
`timescale 1ns/10ps
module tdrs_spi_master #(
    parameter int HALF = 10
) (
    input  wire logic i_ref_clk,
    input  wire logic i_sdo,
    output logic      o_slave_select_n,
    output logic      o_sck,
    output logic      o_sdi
);
    // deselected with the clock parked low
    initial begin
        o_slave_select_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end

    // the data line is not meaningful between frames, so it wanders
    always @(posedge i_ref_clk) begin
        if (o_slave_select_n) begin
            o_sdi <= ~o_sdi;
        end
    end

    // opcode byte then nbits read; halves of HALF clocks keep oversampling
    task automatic frame(input logic [7:0] op, input int nbits,
                         output logic [63:0] rd);
        logic [7:0] sh;
        sh = op;
        rd = '0;
        @(posedge i_ref_clk);
        o_slave_select_n <= 1'b0;
        repeat (HALF) @(posedge i_ref_clk);
        for (int i = 0; i < 8 + nbits; i++) begin
            o_sck <= 1'b1;
            o_sdi <= sh[7];       // msb first, filler after
            sh = {sh[6:0], ~sh[0]};
            repeat (HALF) @(posedge i_ref_clk);
            o_sck <= 1'b0;        // data taken at the fall
            if (i >= 8) begin
                rd = {rd[62:0], i_sdo};
            end
            repeat (HALF) @(posedge i_ref_clk);
        end
        o_slave_select_n <= 1'b1;
        repeat (HALF) @(posedge i_ref_clk); // 200 ns high
    endtask
endmodule

/* File: tdrs_spi_readout.sv */
// tdc readout serial port: spi slave, read registers and nv store control
//
// Operation
// - read opcode 0xbx returns 4/2/1 bytes
// - id opcode sends seven id bytes msb-first
// - addresses 0..3 hold 16.16 results
// - status: pointer, hits ch1, hits ch2
// - bit9 tdc overflow, bit10 precounter overflow
// - bit11 open sensor, bit12 shorted sensor
// - bits13..15: nv equal, uncorrectable, corrected
// - address 5 echoes config one top byte
// - address 8: 1.7 width ratio byte
// - mode two results positive and unsigned
// - uncalibrated: 16-bit count high, low zero
// - calibrated mode one overflow reads all ones
// - calibrated: two's complement reference periods
// - temperature uses mode two format
// - 7x32 nv: store, load, compare only
// - no nv readback except id bytes
// - hamming code, single error triggers refresh
// - four-wire spi with slave select only
// - mode one: clock idles low, falling sample
// - interrupt released on first rising clock
// - slave select high resets the interface
// - bytes whole, msb first
`timescale 1ns/10ps
`include "tdrs_consts.svh"
module tdrs_spi_readout
    import tdrs_pkg::*;
#(
    parameter int RESULTS = 4
) (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_reset_n,
    input  wire logic                    i_slave_select_n,
    input  wire logic                    i_sck,
    input  wire logic                    i_sdi,
    output logic                         o_sdo,
    output logic                         o_sdo_oe_n,
    output logic                         o_interrupt_n,
    input  wire logic                    i_meas_done,
    input  wire logic                    i_measure_mode2,
    input  wire tdrs_result_t            i_result,
    input  wire logic                    i_result_we,
    input  wire logic [1:0]              i_result_sel,
    input  wire tdrs_meas_stat_t         i_meas_stat,
    input  wire logic [7:0]              i_wave_ratio,
    input  wire logic [`TDRS_NV_WORDS*32-1:0] i_config,
    input  wire logic [1:0]              i_nv_inject,
    output logic [`TDRS_NV_WORDS*32-1:0] o_config_load,
    output logic                         o_config_load_valid,
    output logic                         o_nv_busy
);
    // elaboration check: the address decode serves exactly four results
    if (RESULTS != 4) begin
        $error("result register count must be four");
    end

    // pin synchronisers; select idles high, clock idles low
    logic ssn_lvl;
    logic ssn_rise;
    logic ssn_fall;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic sdi_lvl;
    tdrs_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_ssn (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_slave_select_n),
        .o_level   (ssn_lvl),
        .o_rise    (ssn_rise),
        .o_fall    (ssn_fall)
    );
    tdrs_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sck (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_sck),
        .o_level   (sck_lvl),
        .o_rise    (sck_rise),
        .o_fall    (sck_fall)
    );
    tdrs_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sdi (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_sdi),
        .o_level   (sdi_lvl),
        .o_rise    (),
        .o_fall    ()
    );

    // the sdi sync lags sck by the same depth, so sampling on fall is aligned
    wire active = !ssn_lvl;

    // result registers as loaded by the measurement engine
    logic [31:0] result_reg [4];
    logic [31:0] result_next;
    always_comb begin
        if (i_measure_mode2)
            result_next = i_result.value;  // unsigned 16.16
        else if (!i_result.calibrated)
            result_next = {i_result.value[15:0], 16'h0000};
        else if (i_result.alu_overflow)
            result_next = `TDRS_ALU_OVF_VALUE;
        else
            result_next = i_result.value;  // two's complement 16.16
    end

    // one word per result address 0..3
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int r = 0; r < 4; r++)
                result_reg[r] <= 32'h0;
        end else if (i_result_we) begin
            result_reg[i_result_sel] <= result_next;
        end
    end

    // nv store control
    tdrs_nv_op_t nv_op_reg;
    logic        nv_equal;
    logic        nv_sec;
    logic        nv_ded;
    tdrs_nv_store u_nv (
        .i_ref_clk    (i_ref_clk),
        .i_reset_n    (i_reset_n),
        .i_op         (nv_op_reg),
        .i_config     (i_config),
        .i_inject     (i_nv_inject),
        .o_loaded     (o_config_load),
        .o_load_valid (o_config_load_valid),
        .o_equal      (nv_equal),
        .o_single_err (nv_sec),
        .o_multi_err  (nv_ded),
        .o_busy       (o_nv_busy)
    );

    // status word assembled from live engine state and nv result
    logic [15:0] status_word;
    always_comb begin
        status_word = 16'h0000;
        status_word[`TDRS_ST_PTR_LSB +: 3]  = i_meas_stat.next_free_ptr;
        status_word[`TDRS_ST_HIT1_LSB +: 3] = i_meas_stat.hits_ch1;
        status_word[`TDRS_ST_HIT2_LSB +: 3] = i_meas_stat.hits_ch2;
        status_word[`TDRS_ST_TDC_OVF] = i_meas_stat.tdc_overflow;
        status_word[`TDRS_ST_PRE_OVF] = i_meas_stat.precount_overflow;
        status_word[`TDRS_ST_OPEN]    = i_meas_stat.sensor_open;
        status_word[`TDRS_ST_SHORT]   = i_meas_stat.sensor_short;
        status_word[`TDRS_ST_NV_EQ]   = nv_equal;
        status_word[`TDRS_ST_NV_DED]  = nv_ded;
        status_word[`TDRS_ST_NV_SEC]  = nv_sec;
    end

    // serial shifter state
    logic [2:0]  bit_cnt_reg;
    logic        have_op_reg;
    logic [7:0]  op_reg;
    logic [7:0]  rx_reg;
    logic [31:0] tx_reg;
    logic [5:0]  tx_left_reg;
    logic        first_rise_reg;

    wire [7:0] rx_byte = {rx_reg[6:0], sdi_lvl};
    wire       byte_done = sck_fall && bit_cnt_reg == 3'h7;

    // id bytes come from the top of the config image, byte 0 first
    wire [55:0] id_bytes = i_config[`TDRS_NV_WORDS*32-1 -: 56];

    // load word for a read opcode: width picked by address
    logic [31:0] ld_word;
    logic [5:0]  ld_bits;
    always_comb begin
        ld_word = 32'h0;
        ld_bits = 6'd0;
        if (rx_byte == `TDRS_OP_READ_ID) begin
            ld_word = id_bytes[55:24];
            ld_bits = 6'd56;
        end else if (rx_byte == `TDRS_OP_READ_RATIO) begin
            ld_word = {i_wave_ratio, 24'h0};
            ld_bits = 6'd8;
        end else if (rx_byte[7:3] == `TDRS_OP_READ_HI) begin
            case ({1'b0, rx_byte[2:0]})
                `TDRS_ADR_RESULT_ONE, `TDRS_ADR_RESULT_TWO,
                `TDRS_ADR_RESULT_THREE, `TDRS_ADR_RESULT_FOUR: begin
                    ld_word = result_reg[rx_byte[1:0]];
                    ld_bits = 6'd32;
                end
                `TDRS_ADR_STATUS: begin
                    ld_word = {status_word, 16'h0};
                    ld_bits = 6'd16;
                end
                `TDRS_ADR_LINK_ECHO: begin
                    ld_word = {i_config[63:56], 24'h0};  // word one
                    ld_bits = 6'd8;
                end
                default: begin
                    ld_word = 32'h0;
                    ld_bits = 6'd0;
                end
            endcase
        end
    end

    // receive side: sample on falling edge, reset while select is high
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_cnt_reg <= 3'h0;
            rx_reg      <= 8'h00;
            op_reg      <= 8'h00;
            have_op_reg <= 1'b0;
        end else if (!active) begin
            bit_cnt_reg <= 3'h0;
            have_op_reg <= 1'b0;
        end else if (sck_fall) begin
            rx_reg      <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done && !have_op_reg) begin
                op_reg      <= rx_byte;
                have_op_reg <= 1'b1;
            end
        end
    end

    // nv command pulses at the end of the opcode byte; only three exist
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nv_op_reg <= TDRS_NV_NONE;
        end else begin
            nv_op_reg <= TDRS_NV_NONE;
            if (active && byte_done && !have_op_reg) begin
                case (rx_byte)
                    `TDRS_OP_NV_STORE:   nv_op_reg <= TDRS_NV_STORE;
                    `TDRS_OP_NV_LOAD:    nv_op_reg <= TDRS_NV_LOAD;
                    `TDRS_OP_NV_COMPARE: nv_op_reg <= TDRS_NV_COMPARE;
                    default:             nv_op_reg <= TDRS_NV_NONE;
                endcase
            end
        end
    end

    // transmit side: shift on rising edge; id needs a 24-bit refill
    logic        id_refill_reg;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_reg        <= 32'h0;
            tx_left_reg   <= 6'd0;
            o_sdo         <= 1'b0;
            id_refill_reg <= 1'b0;
        end else if (!active) begin
            tx_left_reg   <= 6'd0;
            id_refill_reg <= 1'b0;
            o_sdo         <= 1'b0;
        end else if (byte_done && !have_op_reg) begin
            tx_reg        <= ld_word;
            tx_left_reg   <= ld_bits;
            id_refill_reg <= (rx_byte == `TDRS_OP_READ_ID);
        end else if (sck_rise && tx_left_reg != 6'd0) begin
            o_sdo       <= tx_reg[31];  // msb first
            tx_left_reg <= tx_left_reg - 6'd1;
            if (id_refill_reg && tx_left_reg == 6'd25) begin
                tx_reg        <= {id_bytes[23:0], 8'h00};
                id_refill_reg <= 1'b0;
            end else begin
                tx_reg <= {tx_reg[30:0], 1'b0};
            end
        end
    end

    // data out is driven only while selected
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            o_sdo_oe_n <= 1'b1;
        else
            o_sdo_oe_n <= ssn_lvl;
    end

    // interrupt: set on measurement done, released on first rising clock
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_interrupt_n  <= 1'b1;
            first_rise_reg <= 1'b1;
        end else begin
            if (ssn_fall)
                first_rise_reg <= 1'b1;
            else if (active && sck_rise)
                first_rise_reg <= 1'b0;
            // a completion in the same cycle wins over the release
            if (i_meas_done)
                o_interrupt_n <= 1'b0;
            else if (active && sck_rise && first_rise_reg)
                o_interrupt_n <= 1'b1;
        end
    end
endmodule

/* File: tdrs_spi_readout_chk.sv */
// assertion checker for the tdc readout serial port
`timescale 1ns/10ps
module tdrs_spi_readout_chk (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_slave_select_n,
    input wire logic i_sck,
    input wire logic i_meas_done,
    input wire logic o_sdo,
    input wire logic o_sdo_oe_n,
    input wire logic o_interrupt_n,
    input wire logic o_config_load_valid,
    input wire logic o_nv_busy
);
    // one domain, so clock and reset are given once
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    a_int_set: assert property (
        i_meas_done |-> ##[1:2] !o_interrupt_n) else $error("irq not set");
    a_int_idle: assert property (
        o_interrupt_n && !i_meas_done && !$past(i_meas_done) |=> o_interrupt_n)
        else $error("irq set without cause");
    a_int_hold: assert property (
        (!o_interrupt_n && !i_sck)[*6] |=> !o_interrupt_n)
        else $error("irq released without clock rise");
    a_int_release: assert property (
        $rose(i_sck) && !i_slave_select_n && !o_interrupt_n
        |-> ##[2:8] o_interrupt_n) else $error("irq not released");
    // sync lag is about four clocks, seven leaves a margin
    a_oe_idle: assert property (
        i_slave_select_n[*7] |=> o_sdo_oe_n) else $error("sdo driven idle");
    a_oe_drive: assert property (
        (!i_slave_select_n)[*7] |=> !o_sdo_oe_n) else $error("sdo not driven");
    a_sdo_edge: assert property (
        $changed(o_sdo) && !i_slave_select_n |-> i_sck)
        else $error("sdo moved while clock low");
    a_busy_bound: assert property (
        $rose(o_nv_busy) |-> ##[1:1000] !o_nv_busy) else $error("nv hung");
    a_load_pulse: assert property (
        o_config_load_valid |=> !o_config_load_valid)
        else $error("load valid not a pulse");
endmodule

bind tdrs_spi_readout tdrs_spi_readout_chk u_chk (
    .i_ref_clk,
    .i_reset_n,
    .i_slave_select_n,
    .i_sck,
    .i_meas_done,
    .o_sdo,
    .o_sdo_oe_n,
    .o_interrupt_n,
    .o_config_load_valid,
    .o_nv_busy
);
